// file: inc/ssr_pkg.sv
/*
 * Constants and types of the serial status reporting block: register
 * indices, address layout, field encodings, reset values and timing.
 * Assumes a 50 MHz module clock and a 32-bit classic Wishbone bus.
 */
`default_nettype none
package ssr_pkg;
  // Clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int PULSE_MIN_NS = 1000;
  localparam int PULSE_CYCLES = (PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PULSE_CNT_W = 8;

  // Address layout: word index, per-bit mode flag, bit index
  localparam int ADR_W = 16;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 5;
  localparam int BIT_MODE_POS = 8;
  localparam int BIT_IDX_LSB = 9;
  localparam int BIT_IDX_W = 4;

  // Register word indices
  localparam logic [4:0] REG_FLOW = 5'h00;
  localparam logic [4:0] REG_PARITY = 5'h01;
  localparam logic [4:0] REG_PULSE_MODE = 5'h02;
  localparam logic [4:0] REG_STATUS_BYTE = 5'h03;
  localparam logic [4:0] REG_SRQ_ENABLE = 5'h04;
  localparam logic [4:0] REG_CLEAR_STATUS = 5'h05;
  localparam logic [4:0] REG_STD_EVENT = 5'h06;
  localparam logic [4:0] REG_STD_EVENT_EN = 5'h07;
  localparam logic [4:0] REG_COMM_ERR = 5'h08;
  localparam logic [4:0] REG_COMM_ERR_EN = 5'h09;
  localparam logic [4:0] REG_OVL_COND = 5'h0a;
  localparam logic [4:0] REG_OVL_STATUS = 5'h0b;
  localparam logic [4:0] REG_OVL_STATUS_EN = 5'h0c;
  localparam logic [4:0] REG_EXEC_ERR = 5'h0d;

  // Flow control and parity encodings
  localparam logic [1:0] FLOW_NONE = 2'h0;
  localparam logic [1:0] FLOW_RTS = 2'h1;
  localparam logic [1:0] FLOW_XON = 2'h2;
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_EVEN = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;

  // Reset values
  localparam logic [1:0] FLOW_RST = FLOW_RTS;
  localparam logic [2:0] PAR_RST = PAR_NONE;
  localparam logic PULSE_MODE_RST = 1'b0;
  localparam logic [7:0] MASK_RST = 8'h00;

  // Status byte bit positions
  localparam int STB_OVL_POS = 0;
  localparam int STB_COMM_POS = 1;
  localparam int STB_EVENT_POS = 5;
  localparam int STB_MSS_POS = 6;

  // Execution error codes
  localparam logic [7:0] EXE_NONE = 8'h00;
  localparam logic [7:0] EXE_ILLEGAL_VALUE = 8'h01;
  localparam logic [7:0] EXE_INVALID_BIT = 8'h03;

  // One decoded bus request
  typedef struct packed {
    logic take;
    logic we;
    logic [4:0] idx;
    logic bit_mode;
    logic [3:0] bit_idx;
    logic [31:0] wdat;
  } ssr_req_t;
endpackage : ssr_pkg
`default_nettype wire

// file: rtl/ssr_event_reg.sv
/*
 * Eight-bit sticky event register with per-bit clear and a bulk clear.
 * Assumes set and clear inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ssr_event_reg (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Events and clears
  input wire logic [7:0] set_in,
  input wire logic [7:0] clr_in,
  input wire logic clr_all_in,
  // State
  output logic [7:0] value_out
);
  logic [7:0] value_ff;
  logic [7:0] nxt_value;

  // Arriving events win over any clear in the same cycle
  always_comb begin
    nxt_value = (clr_all_in ? 8'h00 : (value_ff & ~clr_in)) | set_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      value_ff <= 8'h00;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value_out = value_ff;
endmodule : ssr_event_reg
`default_nettype wire

// file: rtl/ssr_pulse_gen.sv
/*
 * Stretches a one-cycle trigger into an active-high pulse of fixed length.
 * Assumes the trigger is a single-cycle pulse on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module ssr_pulse_gen (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Trigger and pulse
  input wire logic trig_in,
  output logic active_out
);
  localparam logic [ssr_pkg::PULSE_CNT_W-1:0] LEN =
    ssr_pkg::PULSE_CNT_W'(ssr_pkg::PULSE_CYCLES);
  logic [ssr_pkg::PULSE_CNT_W-1:0] cnt_ff;

  // A new trigger restarts the full length
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
    end else if (trig_in) begin
      cnt_ff <= LEN;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign active_out = (cnt_ff != '0);
endmodule : ssr_pulse_gen
`default_nettype wire

// file: rtl/ssr_top.sv
/*
 * Status reporting and serial-link configuration registers behind a
 * classic Wishbone slave, with an active-low service request line.
 * Assumes event inputs are single-cycle pulses from same-clock logic and
 * overload condition inputs are asynchronous pins.
 */
// Overview of operation
// - Flow control is held rw: none 0, request-to-send 1, software handshake 2.
// - Reset selects request-to-send flow control.
// - Parity is held rw: none 0, odd 1, even 2, mark 3, space 4.
// - Reset selects no parity.
// - Whole status byte read returns all bits and releases the latched status line, not a running pulse.
// - Single-bit status byte read returns one bit, status line unchanged.
// - Service request mask is rw whole or per addressed bit.
// - Clear status clears standard event, comm-error and overload status together.
// - Standard event register reads whole or per addressed bit.
// - A standard event read clears exactly the bits it returned.
// - Standard event mask is rw whole or per addressed bit.
// - Comm-error status reads whole or per bit, clearing only returned bits.
// - Comm-error mask is rw whole or per addressed bit.
// - Overload condition is read-only live state, whole or per bit.
// - Overload status reads whole or per bit, clearing only returned bits.
// - Overload status mask is rw whole or per addressed bit.
// - In pulse mode each new request pulses the line low at least 1 us.
// - Outside pulse mode a request holds the line low until a full read.
// - Pulse mode is rw, off 0 on 1, and off after reset.
// - Bit indices above 7 are refused with an invalid-bit execution error.
`timescale 1ns/1ps
`default_nettype none
module ssr_top (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [15:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Event sources
  input wire logic [7:0] STD_EVENT_IN,
  input wire logic [7:0] COMM_ERR_EVENT_IN,
  input wire logic [7:0] OVERLOAD_COND_IN,
  input wire logic [7:0] STATUS_AUX_IN,
  // Link settings and status line
  output logic [1:0] FLOW_SEL_OUT,
  output logic [2:0] PARITY_SEL_OUT,
  output logic STATUS_N_OUT
);
  ssr_pkg::ssr_req_t req;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic [1:0] flow_sel_ff;
  logic [2:0] parity_select_ff;
  logic pulse_request_mode_ff;
  logic [7:0] srq_enable_ff;
  logic [7:0] std_event_enable_ff;
  logic [7:0] comm_error_enable_ff;
  logic [7:0] overload_status_enable_ff;
  logic [7:0] exec_err_ff;
  logic [7:0] ovl_meta_ff;
  logic [7:0] overload_condition_ff;
  logic [7:0] ovl_prev_ff;
  logic [7:0] masked_prev_ff;
  logic status_latch_ff;
  logic [7:0] std_event;
  logic [7:0] comm_error_status;
  logic [7:0] overload_status;
  logic [7:0] status_byte;
  logic [7:0] masked;
  logic new_request;
  logic pulse_active;
  logic bit_ok;
  logic [7:0] bit_onehot;
  logic [7:0] rd_clr_mask;
  logic clr_all;
  logic wr_take;
  logic rd_take;
  logic full_stb_read;
  logic [7:0] ev_set [3];
  logic [7:0] ev_clr [3];
  logic [7:0] ev_val [3];

  // Request decode: taken in the cycle before ack rises
  always_comb begin
    req.take = WB_CYC_IN & WB_STB_IN & ~ack_ff;
    req.we = WB_WE_IN;
    req.idx = WB_ADR_IN[ssr_pkg::IDX_LSB +: ssr_pkg::IDX_W];
    req.bit_mode = WB_ADR_IN[ssr_pkg::BIT_MODE_POS];
    req.bit_idx = WB_ADR_IN[ssr_pkg::BIT_IDX_LSB +: ssr_pkg::BIT_IDX_W];
    req.wdat = WB_DAT_IN;
  end

  assign wr_take = req.take & req.we & WB_SEL_IN[0];
  assign rd_take = req.take & ~req.we;
  assign bit_ok = (req.bit_idx[3] == 1'b0);
  assign bit_onehot = 8'h01 << req.bit_idx[2:0];

  // Bits returned by a read are the bits that read clears
  always_comb begin
    if (!req.bit_mode) begin
      rd_clr_mask = 8'hff;
    end else if (bit_ok) begin
      rd_clr_mask = bit_onehot;
    end else begin
      rd_clr_mask = 8'h00;
    end
  end

  assign clr_all = wr_take & (req.idx == ssr_pkg::REG_CLEAR_STATUS);
  assign full_stb_read = rd_take & ~req.bit_mode & (req.idx == ssr_pkg::REG_STATUS_BYTE);

  // Bus acknowledge, one cycle after the request is seen
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req.take;
    end
  end

  // Overload condition pins pass two flip-flops
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      ovl_meta_ff <= 8'h00;
      overload_condition_ff <= 8'h00;
      ovl_prev_ff <= 8'h00;
    end else begin
      ovl_meta_ff <= OVERLOAD_COND_IN;
      overload_condition_ff <= ovl_meta_ff;
      ovl_prev_ff <= overload_condition_ff;
    end
  end

  // Event registers: standard event, comm error, overload status
  always_comb begin
    ev_set[0] = STD_EVENT_IN;
    ev_set[1] = COMM_ERR_EVENT_IN;
    ev_set[2] = overload_condition_ff & ~ovl_prev_ff;
    ev_clr[0] = (rd_take && req.idx == ssr_pkg::REG_STD_EVENT) ? rd_clr_mask : 8'h00;
    ev_clr[1] = (rd_take && req.idx == ssr_pkg::REG_COMM_ERR) ? rd_clr_mask : 8'h00;
    ev_clr[2] = (rd_take && req.idx == ssr_pkg::REG_OVL_STATUS) ? rd_clr_mask : 8'h00;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_event
      ssr_event_reg u_event (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .set_in(ev_set[g]),
        .clr_in(ev_clr[g]),
        .clr_all_in(clr_all),
        .value_out(ev_val[g])
      );
    end
  endgenerate

  assign std_event = ev_val[0];
  assign comm_error_status = ev_val[1];
  assign overload_status = ev_val[2];

  // Status byte with summary bits
  always_comb begin
    status_byte = STATUS_AUX_IN;
    status_byte[ssr_pkg::STB_OVL_POS] = |(overload_status & overload_status_enable_ff);
    status_byte[ssr_pkg::STB_COMM_POS] = |(comm_error_status & comm_error_enable_ff);
    status_byte[ssr_pkg::STB_EVENT_POS] = |(std_event & std_event_enable_ff);
    status_byte[ssr_pkg::STB_MSS_POS] = 1'b0;
    masked = status_byte & srq_enable_ff;
    status_byte[ssr_pkg::STB_MSS_POS] = |masked;
  end

  // Newly set enabled bits raise a request
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      masked_prev_ff <= 8'h00;
    end else begin
      masked_prev_ff <= masked;
    end
  end

  assign new_request = |(masked & ~masked_prev_ff);

  // Latched status line; a fresh request wins over a full read
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      status_latch_ff <= 1'b0;
    end else if (new_request && !pulse_request_mode_ff) begin
      status_latch_ff <= 1'b1;
    end else if (full_stb_read) begin
      status_latch_ff <= 1'b0;
    end
  end

  ssr_pulse_gen u_pulse (
    .clk_in(SYS_CLK_IN),
    .rst_in(SYS_RST_IN),
    .trig_in(new_request & pulse_request_mode_ff),
    .active_out(pulse_active)
  );

  // Link settings
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      flow_sel_ff <= ssr_pkg::FLOW_RST;
    end else if (wr_take && req.idx == ssr_pkg::REG_FLOW
                 && req.wdat[7:0] <= 8'(ssr_pkg::FLOW_XON)) begin
      flow_sel_ff <= req.wdat[1:0];
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      parity_select_ff <= ssr_pkg::PAR_RST;
    end else if (wr_take && req.idx == ssr_pkg::REG_PARITY
                 && req.wdat[7:0] <= 8'(ssr_pkg::PAR_SPACE)) begin
      parity_select_ff <= req.wdat[2:0];
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      pulse_request_mode_ff <= ssr_pkg::PULSE_MODE_RST;
    end else if (wr_take && req.idx == ssr_pkg::REG_PULSE_MODE) begin
      pulse_request_mode_ff <= req.wdat[0];
    end
  end

  // Enable masks, whole or per bit
  function automatic logic [7:0] mask_write(input logic [7:0] cur, input ssr_pkg::ssr_req_t r,
                                            input logic [7:0] onehot, input logic ok);
    logic [7:0] res;
    res = cur;
    if (!r.bit_mode) begin
      res = r.wdat[7:0];
    end else if (ok) begin
      res = r.wdat[0] ? (cur | onehot) : (cur & ~onehot);
    end
    return res;
  endfunction : mask_write

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      srq_enable_ff <= ssr_pkg::MASK_RST;
    end else if (wr_take && req.idx == ssr_pkg::REG_SRQ_ENABLE) begin
      srq_enable_ff <= mask_write(srq_enable_ff, req, bit_onehot, bit_ok);
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      std_event_enable_ff <= ssr_pkg::MASK_RST;
    end else if (wr_take && req.idx == ssr_pkg::REG_STD_EVENT_EN) begin
      std_event_enable_ff <= mask_write(std_event_enable_ff, req, bit_onehot, bit_ok);
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      comm_error_enable_ff <= ssr_pkg::MASK_RST;
    end else if (wr_take && req.idx == ssr_pkg::REG_COMM_ERR_EN) begin
      comm_error_enable_ff <= mask_write(comm_error_enable_ff, req, bit_onehot, bit_ok);
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      overload_status_enable_ff <= ssr_pkg::MASK_RST;
    end else if (wr_take && req.idx == ssr_pkg::REG_OVL_STATUS_EN) begin
      overload_status_enable_ff <= mask_write(overload_status_enable_ff, req, bit_onehot, bit_ok);
    end
  end

  // Execution error: refused values and bad bit indices; read clears
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      exec_err_ff <= ssr_pkg::EXE_NONE;
    end else if (req.take && req.bit_mode && !bit_ok) begin
      exec_err_ff <= ssr_pkg::EXE_INVALID_BIT;
    end else if (wr_take && ((req.idx == ssr_pkg::REG_FLOW
                              && req.wdat[7:0] > 8'(ssr_pkg::FLOW_XON))
                             || (req.idx == ssr_pkg::REG_PARITY
                                 && req.wdat[7:0] > 8'(ssr_pkg::PAR_SPACE)))) begin
      exec_err_ff <= ssr_pkg::EXE_ILLEGAL_VALUE;
    end else if (rd_take && req.idx == ssr_pkg::REG_EXEC_ERR) begin
      exec_err_ff <= ssr_pkg::EXE_NONE;
    end
  end

  // Read data selection
  function automatic logic [31:0] pick(input logic [7:0] v, input ssr_pkg::ssr_req_t r,
                                       input logic ok);
    logic [31:0] res;
    res = 32'h0000_0000;
    if (!r.bit_mode) begin
      res = {24'h00_0000, v};
    end else if (ok) begin
      res = {31'h0000_0000, v[r.bit_idx[2:0]]};
    end
    return res;
  endfunction : pick

  always_comb begin
    case (req.idx)
      ssr_pkg::REG_FLOW: nxt_rdat = {30'h0000_0000, flow_sel_ff};
      ssr_pkg::REG_PARITY: nxt_rdat = {29'h0000_0000, parity_select_ff};
      ssr_pkg::REG_PULSE_MODE: nxt_rdat = {31'h0000_0000, pulse_request_mode_ff};
      ssr_pkg::REG_STATUS_BYTE: nxt_rdat = pick(status_byte, req, bit_ok);
      ssr_pkg::REG_SRQ_ENABLE: nxt_rdat = pick(srq_enable_ff, req, bit_ok);
      ssr_pkg::REG_STD_EVENT: nxt_rdat = pick(std_event, req, bit_ok);
      ssr_pkg::REG_STD_EVENT_EN: nxt_rdat = pick(std_event_enable_ff, req, bit_ok);
      ssr_pkg::REG_COMM_ERR: nxt_rdat = pick(comm_error_status, req, bit_ok);
      ssr_pkg::REG_COMM_ERR_EN: nxt_rdat = pick(comm_error_enable_ff, req, bit_ok);
      ssr_pkg::REG_OVL_COND: nxt_rdat = pick(overload_condition_ff, req, bit_ok);
      ssr_pkg::REG_OVL_STATUS: nxt_rdat = pick(overload_status, req, bit_ok);
      ssr_pkg::REG_OVL_STATUS_EN: nxt_rdat = pick(overload_status_enable_ff, req, bit_ok);
      ssr_pkg::REG_EXEC_ERR: nxt_rdat = {24'h00_0000, exec_err_ff};
      default: nxt_rdat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      rdat_ff <= 32'h0000_0000;
    end else if (rd_take) begin
      rdat_ff <= nxt_rdat;
    end
  end

  assign WB_ACK_OUT = ack_ff;
  assign WB_DAT_OUT = rdat_ff;
  assign FLOW_SEL_OUT = flow_sel_ff;
  assign PARITY_SEL_OUT = parity_select_ff;
  assign STATUS_N_OUT = ~(status_latch_ff | pulse_active);
endmodule : ssr_top
`default_nettype wire

// file: verif/ssr_checker.sv
/* Port-level checks of ssr_top.
   Bound into ssr_top; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ssr_checker (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // Wishbone
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [15:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  // Events and link
  input wire logic [7:0] STD_EVENT_IN,
  input wire logic [7:0] COMM_ERR_EVENT_IN,
  input wire logic [7:0] OVERLOAD_COND_IN,
  input wire logic [7:0] STATUS_AUX_IN,
  input wire logic [1:0] FLOW_SEL_OUT,
  input wire logic [2:0] PARITY_SEL_OUT,
  input wire logic STATUS_N_OUT
);
  localparam int PW = ssr_pkg::PULSE_CYCLES;
  logic take;
  logic rd;
  logic full_rd;
  logic pulse_ff;
  logic [7:0] low_cnt_ff;
  assign take = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
  assign rd = take & ~WB_WE_IN;
  assign full_rd = rd & ~WB_ADR_IN[8] & (WB_ADR_IN[6:2] == ssr_pkg::REG_STATUS_BYTE);
  // Shadow of pulse mode
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) pulse_ff <= 1'b0;
    else if (take & WB_WE_IN & WB_SEL_IN[0] & (WB_ADR_IN[6:2] == ssr_pkg::REG_PULSE_MODE))
      pulse_ff <= WB_DAT_IN[0];
  end
  // Length of the current low period
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN || STATUS_N_OUT) low_cnt_ff <= 8'h00;
    else if (low_cnt_ff != 8'hff) low_cnt_ff <= low_cnt_ff + 8'h01;
  end
  sequence rd_s(logic [4:0] r, logic b);
    rd && WB_ADR_IN[6:2] == r && WB_ADR_IN[8] == b;
  endsequence
  sequence rise_s;
    $rose(STATUS_N_OUT);
  endsequence
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  ack_after_take_a: assert property (take |=> WB_ACK_OUT)
    else $error("no ack after request");
  ack_one_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held too long");
  reset_values_a: assert property ($past(SYS_RST_IN) |->
    FLOW_SEL_OUT == ssr_pkg::FLOW_RTS && PARITY_SEL_OUT == ssr_pkg::PAR_NONE && STATUS_N_OUT)
    else $error("bad values after reset");
  flow_range_a: assert property (FLOW_SEL_OUT <= ssr_pkg::FLOW_XON)
    else $error("flow code out of range");
  parity_range_a: assert property (PARITY_SEL_OUT <= ssr_pkg::PAR_SPACE)
    else $error("parity code out of range");
  line_release_a: assert property (full_rd && !pulse_ff |=> STATUS_N_OUT)
    else $error("full read kept line low");
  bit_read_keep_a: assert property (rd_s(ssr_pkg::REG_STATUS_BYTE, 1'b1) |=>
    $stable(STATUS_N_OUT)) else $error("bit read moved line");
  latch_hold_a: assert property (!pulse_ff && !STATUS_N_OUT && !full_rd |=>
    !STATUS_N_OUT) else $error("latched line released early");
  pulse_width_a: assert property (pulse_ff ##0 rise_s |-> low_cnt_ff >= PW)
    else $error("pulse too short");
  bad_index_a: assert property (rd && WB_ADR_IN[8] && WB_ADR_IN[12] |=>
    WB_DAT_OUT == 32'h0) else $error("bad index read not zero");
  ovl_cond_a: assert property (rd_s(ssr_pkg::REG_OVL_COND, 1'b0) |=>
    WB_DAT_OUT[7:0] == $past(OVERLOAD_COND_IN, 3)) else $error("condition read wrong");
endmodule : ssr_checker
bind ssr_top ssr_checker u_chk (.*);
`default_nettype wire

// file: verif/ssr_host_model.sv
/* Host end of the status line: counts falls and measures low periods.
   Assumes the line is driven on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module ssr_host_model (
  // Clock
  input wire logic clk_in,
  // Status line
  input wire logic status_n_in,
  // Measurements
  output logic [7:0] falls_out,
  output logic [15:0] low_len_out
);
  logic [15:0] run_ff = 16'h0000;
  logic prev_ff = 1'b1;
  logic [7:0] falls_ff = 8'h00;
  logic [15:0] len_ff = 16'h0000;
  assign falls_out = falls_ff;
  assign low_len_out = len_ff;
  always @(posedge clk_in) begin
    if (!status_n_in) run_ff <= run_ff + 16'h0001;
    else if (!prev_ff) begin
      len_ff <= run_ff;
      run_ff <= 16'h0000;
    end
    if (prev_ff && !status_n_in) falls_ff <= falls_ff + 8'h01;
    prev_ff <= status_n_in;
  end
endmodule : ssr_host_model
`default_nettype wire

// file: verif/tb_top.sv
/* Self-checking bench of ssr_top with a host line model.
   Assumes checker bound to ssr_top. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wdat = 32'h0;
  logic [7:0] std_ev = 8'h00;
  logic [7:0] comm_ev = 8'h00;
  logic [7:0] ovl = 8'h00;
  logic [7:0] aux = 8'h00;
  logic [31:0] rdat;
  logic ack;
  logic [1:0] flow;
  logic [2:0] par;
  logic stat_n;
  logic [7:0] falls;
  logic [15:0] low_len;
  logic [31:0] v;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  ssr_top uut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(cyc),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .STD_EVENT_IN(std_ev),
    .COMM_ERR_EVENT_IN(comm_ev), .OVERLOAD_COND_IN(ovl), .STATUS_AUX_IN(aux),
    .FLOW_SEL_OUT(flow), .PARITY_SEL_OUT(par), .STATUS_N_OUT(stat_n));
  ssr_host_model u_host (.clk_in(clk), .status_n_in(stat_n), .falls_out(falls),
    .low_len_out(low_len));
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] r, input logic b, input logic [3:0] i,
    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= {3'h0, i, b, 1'b0, r, 2'h0};
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    v = rdat;
    cyc <= 1'b0;
  endtask : bus
  task automatic ev(input logic [7:0] s, input logic [7:0] c);
    @(posedge clk);
    std_ev <= s;
    comm_ev <= c;
    @(posedge clk);
    std_ev <= 8'h00;
    comm_ev <= 8'h00;
  endtask : ev
  task automatic t_reset();
    chk("flow pin", 32'(flow), 32'h1);
    chk("parity pin", 32'(par), 32'h0);
    bus(0, ssr_pkg::REG_PULSE_MODE, 0, 0, 0);
    chk("pulse mode", v, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_link();
    for (int k = 0; k < 5; k++) begin
      bus(1, ssr_pkg::REG_PARITY, 0, 0, 32'(k));
      bus(0, ssr_pkg::REG_PARITY, 0, 0, 0);
      chk("parity", v, 32'(k));
      chk("parity pin", 32'(par), 32'(k));
      if (k < 3) begin
        bus(1, ssr_pkg::REG_FLOW, 0, 0, 32'(k));
        bus(0, ssr_pkg::REG_FLOW, 0, 0, 0);
        chk("flow", v, 32'(k));
        chk("flow pin", 32'(flow), 32'(k));
      end
    end
    bus(1, ssr_pkg::REG_FLOW, 0, 0, 32'h3);
    bus(0, ssr_pkg::REG_EXEC_ERR, 0, 0, 0);
    chk("flow refused", 32'({v[7:0], 6'h0, flow}), 32'h0102);
    bus(1, ssr_pkg::REG_PARITY, 0, 0, 32'h5);
    bus(0, ssr_pkg::REG_EXEC_ERR, 0, 0, 0);
    chk("parity refused", 32'({v[7:0], 5'h0, par}), 32'h0104);
    $display("test link done");
  endtask : t_link
  task automatic t_masks();
    logic [4:0] m [4] = '{ssr_pkg::REG_SRQ_ENABLE, ssr_pkg::REG_STD_EVENT_EN,
      ssr_pkg::REG_COMM_ERR_EN, ssr_pkg::REG_OVL_STATUS_EN};
    for (int k = 0; k < 4; k++) begin
      bus(1, m[k], 0, 0, 32'ha5);
      bus(1, m[k], 1, 4'h1, 32'h1);
      bus(1, m[k], 1, 4'h0, 32'h0);
      bus(1, m[k], 1, 4'hc, 32'h1);
      bus(0, m[k], 0, 0, 0);
      chk("mask", v, 32'ha6);
      bus(0, m[k], 1, 4'h2, 0);
      chk("mask bit", v, 32'h1);
      bus(1, m[k], 0, 0, 0);
    end
    $display("test masks done");
  endtask : t_masks
  task automatic t_events();
    ev(8'h81, 8'h42);
    bus(0, ssr_pkg::REG_STD_EVENT, 1, 4'h7, 0);
    chk("event bit", v, 32'h1);
    bus(0, ssr_pkg::REG_STD_EVENT, 0, 0, 0);
    chk("event rest", v, 32'h01);
    bus(0, ssr_pkg::REG_COMM_ERR, 1, 4'h6, 0);
    bus(0, ssr_pkg::REG_COMM_ERR, 0, 0, 0);
    chk("comm rest", v, 32'h02);
    ovl <= 8'h03;
    repeat (4) @(posedge clk);
    bus(0, ssr_pkg::REG_OVL_STATUS, 1, 4'h0, 0);
    bus(0, ssr_pkg::REG_OVL_STATUS, 0, 0, 0);
    chk("ovl rest", v, 32'h02);
    bus(0, ssr_pkg::REG_OVL_COND, 0, 0, 0);
    chk("ovl cond", v, 32'h03);
    ovl <= 8'h13;
    ev(8'h04, 8'h08);
    bus(1, ssr_pkg::REG_CLEAR_STATUS, 0, 0, 32'h1);
    bus(0, ssr_pkg::REG_STD_EVENT, 0, 0, 0);
    chk("cleared event", v, 32'h0);
    bus(0, ssr_pkg::REG_COMM_ERR, 0, 0, 0);
    chk("cleared comm", v, 32'h0);
    bus(0, ssr_pkg::REG_OVL_STATUS, 0, 0, 0);
    chk("cleared ovl", v, 32'h0);
    ovl <= 8'h00;
    $display("test events done");
  endtask : t_events
  task automatic t_latch();
    bus(1, ssr_pkg::REG_STD_EVENT_EN, 0, 0, 32'h01);
    bus(1, ssr_pkg::REG_SRQ_ENABLE, 0, 0, 32'h20);
    ev(8'h01, 8'h00);
    repeat (4) @(posedge clk);
    bus(0, ssr_pkg::REG_STATUS_BYTE, 1, 4'h5, 0);
    chk("summary bit", 32'({v[3:0], 3'h0, stat_n}), 32'h10);
    bus(0, ssr_pkg::REG_STATUS_BYTE, 1, 4'h9, 0);
    chk("bad index", v, 32'h0);
    bus(0, ssr_pkg::REG_EXEC_ERR, 0, 0, 0);
    chk("index error", 32'({v[7:0], 7'h0, stat_n}), 32'h0300);
    bus(0, ssr_pkg::REG_STATUS_BYTE, 0, 0, 0);
    chk("status byte", 32'({v[7:0], 7'h0, stat_n}), 32'h6001);
    bus(0, ssr_pkg::REG_STD_EVENT, 0, 0, 0);
    bus(1, ssr_pkg::REG_SRQ_ENABLE, 0, 0, 0);
    $display("test latch done");
  endtask : t_latch
  task automatic t_pulse();
    logic [7:0] n;
    bus(1, ssr_pkg::REG_PULSE_MODE, 0, 0, 32'h1);
    bus(0, ssr_pkg::REG_PULSE_MODE, 0, 0, 0);
    chk("pulse on", v, 32'h1);
    bus(1, ssr_pkg::REG_SRQ_ENABLE, 0, 0, 32'h10);
    n = falls;
    aux <= 8'h10;
    repeat (70) @(posedge clk);
    chk("falls", 32'(falls), 32'(n + 8'h01));
    chk("width", 32'(low_len), 32'(ssr_pkg::PULSE_CYCLES));
    aux <= 8'h00;
    bus(1, ssr_pkg::REG_SRQ_ENABLE, 0, 0, 0);
    bus(1, ssr_pkg::REG_PULSE_MODE, 0, 0, 0);
    $display("test pulse done");
  endtask : t_pulse
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_link();
    t_masks();
    t_events();
    t_latch();
    t_pulse();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
